// ### sector_builder.sv
// Builds the disk information sector byte stream from APB-set fields
// What this block does
// - Sector is exactly 8192 bytes, counted from zero
// - Bytes 0 and 1 both hold D1
// - Bytes 2-6 nine-digit serial, side nibble A/B
// - Bytes 8-15 carry eight ASCII maker characters
// - Byte 7 carries the revision number
// - Byte 16 is year minus 2000
// - Month 1..12 in byte 17, day 1..31 in 18
// - Bytes 19-22 recorder serial, MSB first
// - Byte 23: 0 rewritable, 1 write-once
// - Bytes 24-25 capacity 001E big-endian
// - Byte 26 sector size code 8
// - Byte 27 pitch code 80 or 74
// - Byte 28 wavelength code 81
// - Byte 29 lens aperture code 70
// - Bytes 30-31 refractive index, MSB first
// - Bytes 32-35 nominal and per-radius thickness
// - Byte 36 rotation code 130 or 140
// - Byte 37 read power 100, byte 38 maximum
// - Byte 39 reflectance, byte 40 00/FF contrast
// - Byte 41 maximum writing velocity times ten
// - Bytes 42-44 band erase bitmap, bands 0-16
// - Write-once media: band bitmap all zero
`timescale 1ns/1ps
`include "disk_info_defs.svh"
module sector_builder
  import disk_info_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] sector_data,
  output logic sector_valid,
  input wire logic sector_ready,
  output logic sector_first,
  output logic sector_last
);
  builder_state_t st_reg;
  builder_state_t st_next;
  logic [12:0] count;
  logic at_last;
  logic handshake;
  logic setup_ph;
  logic wr_acc;
  logic mapped;
  logic busy;
  logic start_req;
  logic date_ok;
  logic start_ok;
  logic [12:0] next_off;
  logic [7:0] next_byte;

  // ------------------------------------------------------------
  // Byte image of the sector
  // ------------------------------------------------------------
  function automatic logic [7:0] byte_at(input logic [12:0] off, input builder_state_t s);
    logic [15:0] yoff;
    logic [7:0] b;
    logic [15:0] cap;
    cap = `CAPACITY_GB;
    yoff = s.year - `YEAR_BASE;
    b = 8'h00;
    case (off)
      13'h0000, 13'h0001: b = `SEC_ID_BYTE;
      13'h0002: b = s.serial[35:28];
      13'h0003: b = s.serial[27:20];
      13'h0004: b = s.serial[19:12];
      13'h0005: b = s.serial[11:4];
      13'h0006: b = {s.serial[3:0], s.side_b ? `SIDE_B_CODE : `SIDE_A_CODE};
      13'h0007: b = s.revision;
      13'h0008: b = s.maker[63:56];
      13'h0009: b = s.maker[55:48];
      13'h000A: b = s.maker[47:40];
      13'h000B: b = s.maker[39:32];
      13'h000C: b = s.maker[31:24];
      13'h000D: b = s.maker[23:16];
      13'h000E: b = s.maker[15:8];
      13'h000F: b = s.maker[7:0];
      13'h0010: b = yoff[7:0];
      13'h0011: b = s.month;
      13'h0012: b = s.day;
      13'h0013: b = s.recorder_sn[31:24];
      13'h0014: b = s.recorder_sn[23:16];
      13'h0015: b = s.recorder_sn[15:8];
      13'h0016: b = s.recorder_sn[7:0];
      13'h0017: b = s.write_once ? `KIND_ONCE : `KIND_REWRITE;
      13'h0018: b = cap[15:8];
      13'h0019: b = cap[7:0];
      13'h001A: b = `SECTOR_KB;
      13'h001B: b = s.write_once ? `PITCH_ONCE : `PITCH_REWRITE;
      13'h001C: b = `WAVELENGTH_CODE;
      13'h001D: b = `APERTURE_CODE;
      13'h001E: b = s.cover_index[15:8];
      13'h001F: b = s.cover_index[7:0];
      13'h0020: b = s.thick[31:24];
      13'h0021: b = s.thick[23:16];
      13'h0022: b = s.thick[15:8];
      13'h0023: b = s.thick[7:0];
      13'h0024: b = s.write_once ? `ROT_ONCE : `ROT_REWRITE;
      13'h0025: b = `READ_PWR_CODE;
      13'h0026: b = s.max_read_pwr;
      13'h0027: b = s.reflectance;
      13'h0028: b = s.mark_dark ? `MARK_DARK : `MARK_BRIGHT;
      13'h0029: b = s.max_velocity;
      // Upper seven bits of byte 42 always zero
      13'h002A: b = s.write_once ? 8'h00 : {7'h00, s.bands[16]};
      13'h002B: b = s.write_once ? 8'h00 : s.bands[15:8];
      13'h002C: b = s.write_once ? 8'h00 : s.bands[7:0];
      // Remaining bytes go out as zero; parameter pages not built here
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ------------------------------------------------------------
  // Offset counter
  // ------------------------------------------------------------
  byte_counter u_counter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(start_ok),
    .advance(handshake),
    .count(count),
    .at_last(at_last)
  );

  assign busy = (st_reg.fsm == ST_SEND);
  assign handshake = busy && sector_ready;
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `REG_BANDS);
  assign start_req = wr_acc && mapped && (paddr == `REG_CTRL) && pwdata[`CTRL_START_BIT];
  // Month and day checked before the record is started
  assign date_ok = (st_reg.month >= 8'h01) && (st_reg.month <= `MONTH_MAX)
                && (st_reg.day >= 8'h01) && (st_reg.day <= `DAY_MAX);
  assign start_ok = start_req && !busy && date_ok;
  assign next_off = start_ok ? 13'h0000 : count + 13'h0001;
  assign next_byte = byte_at(next_off, st_reg);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Config writes while busy would corrupt the stream mid-record
    if (wr_acc && mapped && !busy) begin
      if (paddr == `REG_CTRL) begin
        st_next.write_once = pwdata[`CTRL_ONCE_BIT];
        st_next.side_b = pwdata[`CTRL_SIDE_B_BIT];
      end else if (paddr == `REG_SERIAL_LO) begin
        st_next.serial[31:0] = pwdata;
      end else if (paddr == `REG_SERIAL_HI) begin
        st_next.serial[35:32] = pwdata[3:0];
      end else if (paddr == `REG_MAKER_LO) begin
        st_next.maker[31:0] = pwdata;
      end else if (paddr == `REG_MAKER_HI) begin
        st_next.maker[63:32] = pwdata;
      end else if (paddr == `REG_DATE) begin
        st_next.year = pwdata[15:0];
        st_next.month = pwdata[23:16];
        st_next.day = pwdata[31:24];
      end else if (paddr == `REG_MISC) begin
        st_next.revision = pwdata[7:0];
        st_next.reflectance = pwdata[15:8];
        st_next.mark_dark = pwdata[16];
      end else if (paddr == `REG_RECORDER_SN) begin
        st_next.recorder_sn = pwdata;
      end else if (paddr == `REG_OPTICS) begin
        st_next.cover_index = pwdata[15:0];
        st_next.max_read_pwr = pwdata[23:16];
        st_next.max_velocity = pwdata[31:24];
      end else if (paddr == `REG_THICK) begin
        st_next.thick = pwdata;
      end else if (paddr == `REG_BANDS) begin
        st_next.bands = pwdata[16:0];
      end
    end
    // Write-one-to-clear; a same-cycle event below still wins
    if (wr_acc && (paddr == `REG_STATUS)) begin
      if (pwdata[`STAT_DONE_BIT]) begin
        st_next.done = 1'b0;
      end
      if (pwdata[`STAT_ERR_BIT]) begin
        st_next.cfg_err = 1'b0;
      end
    end
    if (start_req && !busy && !date_ok) begin
      st_next.cfg_err = 1'b1;
    end
    case (st_reg.fsm)
      ST_IDLE: begin
        if (start_ok) begin
          st_next.fsm = ST_SEND;
          st_next.done = 1'b0;
          st_next.out_data = next_byte;
        end
      end
      ST_SEND: begin
        if (handshake) begin
          if (at_last) begin
            st_next.fsm = ST_IDLE;
            st_next.done = 1'b1;
          end else begin
            st_next.out_data = next_byte;
          end
        end
      end
      default: st_next.fsm = ST_IDLE;
    endcase
    // Read data captured in the setup cycle, so zero-wait access
    if (setup_ph && !pwrite) begin
      st_next.prdata = 32'h0000_0000;
      if (paddr == `REG_CTRL) begin
        st_next.prdata = {29'h0, st_reg.side_b, st_reg.write_once, 1'b0};
      end else if (paddr == `REG_STATUS) begin
        st_next.prdata = {3'h0, count, 13'h0, st_reg.cfg_err, st_reg.done, busy};
      end else if (paddr == `REG_SERIAL_LO) begin
        st_next.prdata = st_reg.serial[31:0];
      end else if (paddr == `REG_SERIAL_HI) begin
        st_next.prdata = {28'h0, st_reg.serial[35:32]};
      end else if (paddr == `REG_MAKER_LO) begin
        st_next.prdata = st_reg.maker[31:0];
      end else if (paddr == `REG_MAKER_HI) begin
        st_next.prdata = st_reg.maker[63:32];
      end else if (paddr == `REG_DATE) begin
        st_next.prdata = {st_reg.day, st_reg.month, st_reg.year};
      end else if (paddr == `REG_MISC) begin
        st_next.prdata = {15'h0, st_reg.mark_dark, st_reg.reflectance, st_reg.revision};
      end else if (paddr == `REG_RECORDER_SN) begin
        st_next.prdata = st_reg.recorder_sn;
      end else if (paddr == `REG_OPTICS) begin
        st_next.prdata = {st_reg.max_velocity, st_reg.max_read_pwr, st_reg.cover_index};
      end else if (paddr == `REG_THICK) begin
        st_next.prdata = st_reg.thick;
      end else if (paddr == `REG_BANDS) begin
        st_next.prdata = {15'h0, st_reg.bands};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata = st_reg.prdata;
  assign pready = 1'b1;
  // Config writes during a record are refused, except to CTRL, which are dropped without error
  assign pslverr = psel && penable && (!mapped || (pwrite && busy && (paddr != `REG_STATUS)
                   && (paddr != `REG_CTRL)));
  assign sector_data = st_reg.out_data;
  assign sector_valid = busy;
  assign sector_first = busy && (count == 13'h0000);
  assign sector_last = busy && at_last;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence last_taken;
    handshake && at_last;
  endsequence
  sequence back_idle;
    !sector_valid && st_reg.done;
  endsequence
  sequence start_taken;
    start_ok;
  endsequence
  sequence first_shown;
    sector_valid && sector_first && (sector_data == `SEC_ID_BYTE);
  endsequence

  AST_RECORD_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    last_taken |=> back_idle)
    else $error("record did not end after last byte");
  AST_START_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_taken |=> first_shown)
    else $error("record did not open with identifier byte");
  AST_ID_BYTES: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count <= 13'h0001) |-> (sector_data == 8'hD1))
    else $error("identifier byte is not D1");
  AST_SIDE_NIBBLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h0006) |-> (sector_data[3:0] inside {4'hA, 4'hB}))
    else $error("side nibble not A or B");
  AST_YEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h0010) |-> (sector_data + 16'd2000 == st_reg.year[15:0]
     || st_reg.year > 16'd2255))
    else $error("year byte not offset from 2000");
  AST_MONTH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h0011) |-> (sector_data >= 8'h01 && sector_data <= 8'h0C))
    else $error("month out of range in stream");
  AST_DAY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h0012) |-> (sector_data >= 8'h01 && sector_data <= 8'h1F))
    else $error("day out of range in stream");
  AST_BAD_DATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (start_req && !busy && !date_ok) |=> (st_reg.cfg_err && !sector_valid))
    else $error("start with bad date not refused");
  AST_RECORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (handshake && count == 13'h0013) |=> (sector_data == st_reg.recorder_sn[23:16]))
    else $error("recorder serial order wrong");
  AST_KIND: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h0017) |-> (sector_data == {7'h00, st_reg.write_once}))
    else $error("media kind byte wrong");
  AST_CAPACITY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h0019) |-> (sector_data == 8'h1E))
    else $error("capacity low byte wrong");
  AST_SECTOR_SIZE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h001A) |-> (sector_data == 8'h08))
    else $error("sector size code wrong");
  AST_PITCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h001B) |->
    (sector_data == (st_reg.write_once ? 8'h4A : 8'h50)))
    else $error("track pitch code wrong for media kind");
  AST_WAVELENGTH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h001C) |-> (sector_data == 8'h51))
    else $error("wavelength code wrong");
  AST_APERTURE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h001D) |-> (sector_data == 8'h46))
    else $error("lens aperture code wrong");
  AST_ROTATION: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h0024) |-> (sector_data == (st_reg.write_once ? 8'h8C : 8'h82)))
    else $error("rotation code wrong for media kind");
  AST_READ_PWR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h0025) |-> (sector_data == 8'h64))
    else $error("read power code wrong");
  AST_CONTRAST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h0028) |-> (sector_data inside {8'h00, 8'hFF}))
    else $error("mark contrast byte not 00 or FF");
  AST_BAND_TOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && count == 13'h002A) |-> (sector_data[7:1] == 7'h00))
    else $error("upper bits of band byte not zero");
  AST_ONCE_BANDS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && st_reg.write_once && count >= 13'h002A && count <= 13'h002C)
    |-> (sector_data == 8'h00))
    else $error("band bitmap nonzero on write-once media");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sector_valid && !sector_ready) |=> (sector_valid && $stable(sector_data)
     && $stable(count)))
    else $error("stream byte changed while stalled");
endmodule // sector_builder

// ### disk_info_defs.svh
// Constants for the disk information sector builder
`ifndef DISK_INFO_DEFS_SVH
`define DISK_INFO_DEFS_SVH
// ------------------------------------------------------------
// Sector layout
// ------------------------------------------------------------
`define SEC_BYTES 14'h2000
`define SEC_LAST 13'h1FFF
`define SEC_ID_BYTE 8'hD1
`define SIDE_A_CODE 4'hA
`define SIDE_B_CODE 4'hB
`define YEAR_BASE 16'h07D0
`define MONTH_MAX 8'h0C
`define DAY_MAX 8'h1F
`define KIND_REWRITE 8'h00
`define KIND_ONCE 8'h01
`define CAPACITY_GB 16'h001E
`define SECTOR_KB 8'h08
`define PITCH_REWRITE 8'h50
`define PITCH_ONCE 8'h4A
`define WAVELENGTH_CODE 8'h51
`define APERTURE_CODE 8'h46
`define ROT_REWRITE 8'h82
`define ROT_ONCE 8'h8C
`define READ_PWR_CODE 8'h64
`define MARK_BRIGHT 8'h00
`define MARK_DARK 8'hFF
// ------------------------------------------------------------
// Register offsets and fields
// ------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SERIAL_LO 8'h08
`define REG_SERIAL_HI 8'h0C
`define REG_MAKER_LO 8'h10
`define REG_MAKER_HI 8'h14
`define REG_DATE 8'h18
`define REG_MISC 8'h1C
`define REG_RECORDER_SN 8'h20
`define REG_OPTICS 8'h24
`define REG_THICK 8'h28
`define REG_BANDS 8'h2C
`define CTRL_START_BIT 0
`define CTRL_ONCE_BIT 1
`define CTRL_SIDE_B_BIT 2
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_ERR_BIT 2
`endif

// ### disk_info_pkg.sv
// Types shared by the disk information sector builder
package disk_info_pkg;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } builder_fsm_t;

  typedef struct packed {
    logic [12:0] count;
  } counter_state_t;

  typedef struct packed {
    builder_fsm_t fsm;
    logic write_once;
    logic side_b;
    logic [35:0] serial;
    logic [63:0] maker;
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] revision;
    logic [7:0] reflectance;
    logic mark_dark;
    logic [31:0] recorder_sn;
    logic [15:0] cover_index;
    logic [7:0] max_read_pwr;
    logic [7:0] max_velocity;
    logic [31:0] thick;
    logic [16:0] bands;
    logic done;
    logic cfg_err;
    logic [7:0] out_data;
    logic [31:0] prdata;
  } builder_state_t;
endpackage

// ### byte_counter.sv
// Byte offset counter for one sector record
`timescale 1ns/1ps
`include "disk_info_defs.svh"
module byte_counter
  import disk_info_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic advance,
  output logic [12:0] count,
  output logic at_last
);
  counter_state_t st_reg;
  counter_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.count = 13'h0000;
    end else if (advance) begin
      st_next.count = st_reg.count + 13'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.count;
  assign at_last = (st_reg.count == `SEC_LAST);

  AST_WRAP_FREE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (advance && !clear && at_last) |=> (count == 13'h0000))
    else $error("counter did not wrap after last byte");
endmodule // byte_counter

// ### sector_sink.sv
// Sink model of the drive write path that collects one record
`timescale 1ns/1ps
module sector_sink (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sector_data,
  input wire logic sector_valid,
  input wire logic sector_first,
  input wire logic sector_last,
  input wire logic stall_en,
  output logic sector_ready
);
  logic [7:0] rec [0:8191];
  logic [31:0] pos;
  logic [31:0] count;
  logic [31:0] flag_bad;
  logic [2:0] phase;
  logic kind_once;
  logic fixed_err;

  // Parser side: identifier and fixed fields by media kind
  function automatic logic fixed_bad(input logic [31:0] p, input logic [7:0] d, input logic o);
    logic bad;
    bad = 1'b0;
    case (p)
      32'h0, 32'h1: bad = (d !== 8'hD1);
      32'h18: bad = (d !== 8'h00);
      32'h19: bad = (d !== 8'h1E);
      32'h1A: bad = (d !== 8'h08);
      32'h1B: bad = (d !== (o ? 8'h4A : 8'h50));
      32'h1C: bad = (d !== 8'h51);
      32'h1D: bad = (d !== 8'h46);
      32'h24: bad = (d !== (o ? 8'h8C : 8'h82));
      32'h25: bad = (d !== 8'h64);
      default: bad = 1'b0;
    endcase
    return bad;
  endfunction
  // --------------------------------------------------------------
  // Acceptance, one byte per handshake
  // --------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 32'h0;
      count <= 32'h0;
      flag_bad <= 32'h0;
      phase <= 3'h0;
      kind_once <= 1'b0;
      fixed_err <= 1'b0;
      sector_ready <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      // Stall one cycle in eight so held bytes are exercised
      sector_ready <= !(stall_en && phase == 3'h5);
      if (!sector_valid) begin
        pos <= 32'h0;
      end else if (sector_ready) begin
        rec[pos[12:0]] <= sector_data;
        pos <= pos + 32'h1;
        count <= pos + 32'h1;
        if (sector_first !== (pos == 32'h0) || sector_last !== (pos == 32'h1FFF)) begin
          flag_bad <= flag_bad + 32'h1;
        end
        if (pos == 32'h17) begin
          kind_once <= sector_data[0];
        end
        if (fixed_bad(pos, sector_data, kind_once)) begin
          fixed_err <= 1'b1;
        end
        if (pos > 32'h1FFF) begin
          flag_bad <= flag_bad + 32'h1;
        end
      end
    end
  end
endmodule // sector_sink

// ### sector_builder_test.sv
// Self-checking bench for the sector builder
`timescale 1ns/1ps
`include "disk_info_defs.svh"
module sector_builder_test
  import disk_info_pkg::*;
;
  logic ref_clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] sector_data;
  logic sector_valid;
  logic sector_ready;
  logic sector_first;
  logic sector_last;
  logic stall_en;
  int errors;
  int tests_run;
  int cycles = 0;
  logic [31:0] q;
  logic e;
  logic once;
  logic sb;
  logic md;
  logic [7:0] yr;
  logic [7:0] mo;
  logic [7:0] dy;
  logic [7:0] cfg_a [0:8] = '{`REG_SERIAL_LO, `REG_SERIAL_HI, `REG_MAKER_HI, `REG_MAKER_LO,
    `REG_MISC, `REG_RECORDER_SN, `REG_OPTICS, `REG_THICK, `REG_BANDS};
  logic [31:0] cfg_d [0:8] = '{32'h2345_6789, 32'h0000_0001, 32'h4142_4344, 32'h4546_4748,
    32'h0001_2A05, 32'hDEAD_BEEF, 32'h3C78_3A98, 32'h6465_6667, 32'h0001_2345};
  logic [7:0] bad_mo [0:3] = '{8'h00, 8'h0D, 8'h01, 8'h01};
  logic [7:0] bad_dy [0:3] = '{8'h01, 8'h01, 8'h00, 8'h20};

  sector_builder i_sector_builder (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sector_data(sector_data),
    .sector_valid(sector_valid), .sector_ready(sector_ready),
    .sector_first(sector_first), .sector_last(sector_last));
  sector_sink i_sector_sink (.ref_clk(ref_clk), .rst_n(rst_n), .sector_data(sector_data),
    .sector_valid(sector_valid), .sector_first(sector_first), .sector_last(sector_last),
    .stall_en(stall_en), .sector_ready(sector_ready));

  // --------------------------------------------------------------
  // Clock and hang guard
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic tally_and_finish();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] exp_byte(input int i);
    logic [7:0] t [0:44];
    t = '{8'hD1, 8'hD1, 8'h12, 8'h34, 8'h56, 8'h78, {4'h9, sb ? 4'hB : 4'hA}, 8'h05,
      8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, yr, mo, dy,
      8'hDE, 8'hAD, 8'hBE, 8'hEF, {7'h00, once}, 8'h00, 8'h1E, 8'h08,
      once ? 8'h4A : 8'h50, 8'h51, 8'h46, 8'h3A, 8'h98, 8'h64, 8'h65, 8'h66, 8'h67,
      once ? 8'h8C : 8'h82, 8'h64, 8'h78, 8'h2A, md ? 8'hFF : 8'h00, 8'h3C,
      once ? 8'h00 : 8'h01, once ? 8'h00 : 8'h23, once ? 8'h00 : 8'h45};
    return (i < 45) ? t[i] : 8'h00;
  endfunction

  // One whole record, with a refused field write while busy
  task automatic run(input logic o, input logic s, input logic st);
    int n;
    once = o;
    sb = s;
    stall_en <= st;
    apb(1'b1, `REG_DATE, {dy, mo, 16'h07D0 + {8'h00, yr}});
    apb(1'b1, `REG_CTRL, {29'h0, s, o, 1'b1});
    apb(1'b1, `REG_SERIAL_LO, 32'h0);
    check(e, 1'b1);
    // Restart while busy must be ignored without error
    apb(1'b1, `REG_CTRL, {29'h0, ~s, ~o, 1'b1});
    check(e, 1'b0);
    n = 0;
    q = 32'h0;
    while (q[1] !== 1'b1 && n < 20000) begin
      apb(1'b0, `REG_STATUS, 32'h0);
      n++;
    end
    check(q[2:0], 3'h2);
    check(sector_valid, 1'b0);
    check(i_sector_sink.count, 32'd8192);
    check(i_sector_sink.fixed_err, 1'b0);
    check(i_sector_sink.flag_bad, 32'h0);
    for (int i = 0; i < 23; i++) begin
      check(i_sector_sink.rec[i], exp_byte(i));
    end
    for (int i = 23; i < 36; i++) begin
      check(i_sector_sink.rec[i], exp_byte(i));
    end
    for (int i = 36; i < 8192; i++) begin
      check(i_sector_sink.rec[i], exp_byte(i));
    end
    apb(1'b1, `REG_STATUS, 32'h6);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(q[2:0], 3'h0);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stall_en = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, `REG_STATUS, 32'h0);
    check(q, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check(q, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'b1, 8'h02, 32'h0);
    check(e, 1'b1);
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, cfg_a[k], cfg_d[k]);
      apb(1'b0, cfg_a[k], 32'h0);
      check(q, cfg_d[k]);
    end
    md = 1'b1;
    // Date limits 12/31 then 1/1, stalled sink first
    yr = 8'h17;
    mo = 8'h0C;
    dy = 8'h1F;
    run(1'b0, 1'b0, 1'b1);
    yr = 8'h00;
    mo = 8'h01;
    dy = 8'h01;
    // Brighter marks on the second record
    md = 1'b0;
    apb(1'b1, `REG_MISC, 32'h0000_2A05);
    run(1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `REG_DATE, {bad_dy[k], bad_mo[k], 16'h07E7});
      apb(1'b1, `REG_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk);
      check(sector_valid, 1'b0);
      apb(1'b0, `REG_STATUS, 32'h0);
      check(q[2:0], 3'h4);
      apb(1'b1, `REG_STATUS, 32'h6);
    end
    tally_and_finish();
  end
endmodule // sector_builder_test
